// file: hw/flash_seq_pkg.sv
package flash_seq_pkg;
    // device command codes
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CHIP_SETUP  = 8'h30;
    localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
    localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
    localparam logic [7:0] CMD_WRITE_ALT   = 8'h10;
    localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
    localparam logic [7:0] CMD_CLEAR_DEF   = 8'h50;

    // status_word bit positions
    localparam int SB_READY   = 7;
    localparam int SB_ERASE   = 5;
    localparam int SB_WRITE   = 4;
    localparam int SB_SUPPLY  = 3;
    localparam int SB_PROTECT = 1;

    // controller operations
    typedef enum logic [2:0] {
        OP_CHIP_ERASE  = 3'h0,
        OP_WORD_WRITE  = 3'h1,
        OP_CLEAR       = 3'h2,
        OP_READ_ARRAY  = 3'h3,
        OP_READ_STATUS = 3'h4
    } op_t;

    // register indexes on the software port
    localparam logic [3:0] REG_CTRL  = 4'h0;
    localparam logic [3:0] REG_ADDR  = 4'h1;
    localparam logic [3:0] REG_WDATA = 4'h2;
    localparam logic [3:0] REG_STAT  = 4'h3;
    localparam logic [3:0] REG_IRQ   = 4'h4;
    localparam logic [3:0] REG_MASK  = 4'h5;
    localparam logic [3:0] REG_RDATA = 4'h6;

    // control register fields
    localparam int CTRL_OP_LSB   = 0;
    localparam int CTRL_GO       = 3;
    localparam int CTRL_AUTO_ARR = 4;
    localparam int CTRL_CHK_EACH = 5;

    // interrupt bits: done, error, refused, timeout
    localparam int IRQ_W      = 4;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_ERROR  = 1;
    localparam int IRQ_REFUSE = 2;
    localparam int IRQ_TMO    = 3;

    // bus timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int WR_PULSE_NS   = 100;
    localparam int RD_ACCESS_NS  = 120;

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc
endpackage : flash_seq_pkg

// file: hw/flash_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle #(
    parameter int AW = 20,
    parameter int DW = 16
) (
    input  wire logic          clock_i,
    input  wire logic          reset_n_i,
    input  wire logic          start_i,
    input  wire logic          read_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] data_i,
    output logic               busy_o,
    output logic               done_o,
    output logic [DW-1:0]      rdata_o,
    output logic [AW-1:0]      fa_o,
    output logic [DW-1:0]      fd_o,
    input  wire logic [DW-1:0] fd_i,
    output logic               fd_oe_n_o,
    output logic               ce_n_o,
    output logic               we_n_o,
    output logic               oe_n_o
);
    localparam int WR_CYC = flash_seq_pkg::ns_to_cyc(flash_seq_pkg::WR_PULSE_NS);
    localparam int RD_CYC = flash_seq_pkg::ns_to_cyc(flash_seq_pkg::RD_ACCESS_NS);
    localparam logic [7:0] WR_LAST = 8'(WR_CYC - 1);
    localparam logic [7:0] RD_LAST = 8'(RD_CYC - 1);

    logic       rd;
    logic [7:0] cnt;
    wire        last = rd ? (cnt == RD_LAST) : (cnt == WR_LAST);

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
            rd        <= 1'b0;
            cnt       <= 8'h00;
            rdata_o   <= '0;
            fa_o      <= '0;
            fd_o      <= '0;
            fd_oe_n_o <= 1'b1;
            ce_n_o    <= 1'b1;
            we_n_o    <= 1'b1;
            oe_n_o    <= 1'b1;
        end else begin
            done_o <= 1'b0;
            if (!busy_o && start_i) begin
                busy_o    <= 1'b1;
                rd        <= read_i;
                cnt       <= 8'h00;
                fa_o      <= addr_i;
                fd_o      <= data_i;
                fd_oe_n_o <= read_i;
                ce_n_o    <= 1'b0;
                we_n_o    <= read_i;
                oe_n_o    <= !read_i;
            end else if (busy_o && !last) begin
                cnt <= cnt + 8'h01;
            end else if (busy_o) begin
                // strobes rise and data is released together, in the same step at the end of the cycle
                busy_o    <= 1'b0;
                done_o    <= 1'b1;
                ce_n_o    <= 1'b1;
                we_n_o    <= 1'b1;
                oe_n_o    <= 1'b1;
                fd_oe_n_o <= 1'b1;
                if (rd) begin
                    rdata_o <= fd_i;
                end
            end
        end
    end
endmodule : flash_bus_cycle
`default_nettype wire

// file: hw/flash_status_check.sv
`timescale 1ns/1ps
`default_nettype none
module flash_status_check (
    input  wire logic       clock_i,
    input  wire logic       reset_n_i,
    input  wire logic       load_i,
    input  wire logic [7:0] status_word_i,
    output logic            supply_low_o,
    output logic            protect_o,
    output logic            seq_err_o,
    output logic            erase_err_o,
    output logic            write_err_o,
    output logic            any_err_o
);
    wire e5 = status_word_i[flash_seq_pkg::SB_ERASE];
    wire e4 = status_word_i[flash_seq_pkg::SB_WRITE];
    wire e3 = status_word_i[flash_seq_pkg::SB_SUPPLY];
    wire e1 = status_word_i[flash_seq_pkg::SB_PROTECT];

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            supply_low_o <= 1'b0;
            protect_o    <= 1'b0;
            seq_err_o    <= 1'b0;
            erase_err_o  <= 1'b0;
            write_err_o  <= 1'b0;
            any_err_o    <= 1'b0;
        end else if (load_i) begin
            supply_low_o <= e3;
            protect_o    <= e1;
            seq_err_o    <= e5 && e4;
            erase_err_o  <= e5 && !e4;
            write_err_o  <= e4 && !e5;
            any_err_o    <= e5 || e4 || e3 || e1;
        end
    end
endmodule : flash_status_check
`default_nettype wire

// file: hw/flash_seq_host.sv
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module flash_seq_host #(
    parameter int              AW         = 20,
    parameter int              DW         = 16,
    parameter logic [7:0]      CLEAR_CODE = flash_seq_pkg::CMD_CLEAR_DEF,
    parameter logic [7:0]      WRITE_CODE = flash_seq_pkg::CMD_WRITE_SETUP,
    parameter logic [23:0]     POLL_LIMIT = 24'h0fffff
) (
    input  wire logic          CLOCK_I,
    input  wire logic          RESET_N_I,
    input  wire logic [3:0]    ADDR_I,
    input  wire logic [31:0]   WDATA_I,
    input  wire logic          WR_I,
    input  wire logic          RD_I,
    output logic [31:0]        RDATA_O,
    output logic               IRQ_O,
    output logic [AW-1:0]      FA_O,
    output logic [DW-1:0]      FD_O,
    input  wire logic [DW-1:0] FD_I,
    output logic               FD_OE_N_O,
    output logic               CE_N_O,
    output logic               WE_N_O,
    output logic               OE_N_O
);
    typedef enum logic [2:0] {
        S_IDLE, S_PRE_CMD, S_PRE_RD, S_OP_1, S_OP_2, S_POST_RD, S_ARRAY,
        S_FINISH
    } state_t;

    localparam int IRQ_W_L = flash_seq_pkg::IRQ_W;

    ////////////////////////////////////////////////////////////////////////
    // software registers
    state_t                    state;
    state_t                    next_state;
    flash_seq_pkg::op_t        op;
    logic                      auto_array;
    logic                      check_each;
    logic [AW-1:0]             tgt_addr;
    logic [DW-1:0]             wdata;
    logic [7:0]                status_word;
    logic [DW-1:0]             last_read;
    logic                      err_pending;
    logic                      timeout;
    logic [IRQ_W_L-1:0]        irq_stat;
    logic [IRQ_W_L-1:0]        irq_mask;
    logic [23:0]               poll_cnt;
    logic                      issued;
    logic                      cyc_start;
    logic                      cyc_busy;
    logic                      cyc_done;
    logic [DW-1:0]             cyc_rdata;
    logic                      chk_sup, chk_prot, chk_seq, chk_era, chk_wr;
    logic                      chk_any;

    function automatic logic is_reg(input logic [3:0] a,
                                    input logic [3:0] r);
        return a == r;
    endfunction : is_reg

    wire wr_ctrl   = WR_I && is_reg(ADDR_I, flash_seq_pkg::REG_CTRL);
    wire go        = wr_ctrl && WDATA_I[flash_seq_pkg::CTRL_GO];
    wire [2:0] go_op_bits = WDATA_I[flash_seq_pkg::CTRL_OP_LSB +: 3];
    wire go_is_mod = go_op_bits == 3'(flash_seq_pkg::OP_CHIP_ERASE)
                  || go_op_bits == 3'(flash_seq_pkg::OP_WORD_WRITE);
    // erase or write refused while an error is unacknowledged
    wire refuse    = go && state == S_IDLE && err_pending && go_is_mod;
    wire accept    = go && state == S_IDLE && !refuse;
    wire op_mod    = op == flash_seq_pkg::OP_CHIP_ERASE
                  || op == flash_seq_pkg::OP_WORD_WRITE;

    ////////////////////////////////////////////////////////////////////////
    // bus step selection
    wire step_state = state != S_IDLE && state != S_FINISH;
    wire step_read  = state == S_PRE_RD || state == S_POST_RD;
    wire rd_ready   = cyc_rdata[flash_seq_pkg::SB_READY];
    wire poll_end   = poll_cnt == POLL_LIMIT;
    logic [7:0]    op1_code;
    logic [DW-1:0] step_data;
    logic [AW-1:0] step_addr;

    always_comb begin
        case (op)
            flash_seq_pkg::OP_CHIP_ERASE:  op1_code = flash_seq_pkg::CMD_CHIP_SETUP;
            flash_seq_pkg::OP_WORD_WRITE:  op1_code = WRITE_CODE;
            flash_seq_pkg::OP_CLEAR:       op1_code = CLEAR_CODE;
            flash_seq_pkg::OP_READ_ARRAY:  op1_code = flash_seq_pkg::CMD_READ_ARRAY;
            default:                       op1_code = flash_seq_pkg::CMD_READ_STATUS;
        endcase
    end

    always_comb begin
        step_addr = '0;
        case (state)
            S_PRE_CMD: step_data = DW'(flash_seq_pkg::CMD_READ_STATUS);
            S_OP_1:    step_data = DW'(op1_code);
            S_OP_2: begin
                if (op == flash_seq_pkg::OP_WORD_WRITE) begin
                    step_data = wdata;
                    step_addr = tgt_addr;
                end else begin
                    step_data = DW'(flash_seq_pkg::CMD_CONFIRM);
                end
            end
            S_ARRAY:   step_data = DW'(flash_seq_pkg::CMD_READ_ARRAY);
            default:   step_data = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (accept) begin
                    if (go_op_bits == 3'(flash_seq_pkg::OP_CLEAR)
                        || go_op_bits == 3'(flash_seq_pkg::OP_READ_ARRAY)) begin
                        next_state = S_OP_1;
                    end else begin
                        next_state = S_PRE_CMD;
                    end
                end
            end
            S_PRE_CMD: if (cyc_done) next_state = S_PRE_RD;
            S_PRE_RD: begin
                if (cyc_done && rd_ready) begin
                    next_state = op_mod ? S_OP_1 : S_FINISH;
                end else if (cyc_done && poll_end) begin
                    next_state = S_FINISH;
                end
            end
            S_OP_1: if (cyc_done) next_state = op_mod ? S_OP_2 : S_FINISH;
            S_OP_2: if (cyc_done) next_state = S_POST_RD;
            S_POST_RD: begin
                if (cyc_done && rd_ready) begin
                    next_state = auto_array ? S_ARRAY : S_FINISH;
                end else if (cyc_done && poll_end) begin
                    next_state = S_FINISH;
                end
            end
            S_ARRAY:  if (cyc_done) next_state = S_FINISH;
            S_FINISH: next_state = S_IDLE;
            default:  next_state = S_IDLE;
        endcase
    end

    wire status_load = cyc_done && step_read && rd_ready;
    wire tmo_hit     = cyc_done && step_read && !rd_ready && poll_end;
    wire clear_done  = state == S_OP_1 && cyc_done
                    && op == flash_seq_pkg::OP_CLEAR;
    // checked after each erase or write when check_each is set, otherwise only on an explicit status read
    // clear and read-array end without a status read, flags are stale there
    wire err_latch   = state == S_FINISH && chk_any && !timeout
                    && ((op_mod && check_each)
                        || op == flash_seq_pkg::OP_READ_STATUS);

    logic [IRQ_W_L-1:0] irq_ev;
    always_comb begin
        irq_ev = '0;
        irq_ev[flash_seq_pkg::IRQ_DONE]   = state == S_FINISH;
        irq_ev[flash_seq_pkg::IRQ_ERROR]  = err_latch;
        irq_ev[flash_seq_pkg::IRQ_REFUSE] = refuse;
        irq_ev[flash_seq_pkg::IRQ_TMO]    = tmo_hit;
    end
    wire [IRQ_W_L-1:0] irq_clr = (WR_I && is_reg(ADDR_I, flash_seq_pkg::REG_IRQ))
                               ? WDATA_I[IRQ_W_L-1:0] : '0;

    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state     <= S_IDLE;
            issued    <= 1'b0;
            cyc_start <= 1'b0;
            poll_cnt  <= '0;
        end else begin
            state     <= next_state;
            cyc_start <= step_state && !issued && !cyc_busy && !cyc_start;
            issued    <= (issued || cyc_start) && !cyc_done;
            if (accept || status_load) begin
                poll_cnt <= '0;
            end else if (cyc_done && step_read) begin
                poll_cnt <= poll_cnt + 24'h000001;
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            op          <= flash_seq_pkg::OP_READ_STATUS;
            auto_array  <= 1'b0;
            check_each  <= 1'b1;
            tgt_addr    <= '0;
            wdata       <= '0;
            status_word <= 8'h00;
            last_read   <= '0;
            err_pending <= 1'b0;
            timeout     <= 1'b0;
            irq_stat    <= '0;
            irq_mask    <= '0;
        end else begin
            if (accept) begin
                op         <= flash_seq_pkg::op_t'(go_op_bits);
                auto_array <= WDATA_I[flash_seq_pkg::CTRL_AUTO_ARR];
                check_each <= WDATA_I[flash_seq_pkg::CTRL_CHK_EACH];
                timeout    <= 1'b0;
            end else if (tmo_hit) begin
                timeout <= 1'b1;
            end
            if (WR_I && is_reg(ADDR_I, flash_seq_pkg::REG_ADDR)) begin
                tgt_addr <= WDATA_I[AW-1:0];
            end
            if (WR_I && is_reg(ADDR_I, flash_seq_pkg::REG_WDATA)) begin
                wdata <= WDATA_I[DW-1:0];
            end
            if (status_load) begin
                status_word <= cyc_rdata[7:0];
            end
            if (cyc_done && step_read) begin
                last_read <= cyc_rdata;
            end
            if (err_latch) begin
                err_pending <= 1'b1;
            end else if (clear_done) begin
                err_pending <= 1'b0;
            end
            irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
            if (WR_I && is_reg(ADDR_I, flash_seq_pkg::REG_MASK)) begin
                irq_mask <= WDATA_I[IRQ_W_L-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port and interrupt
    wire [31:0] stat_word = {16'h0000, timeout, chk_wr, chk_era, chk_seq,
                             chk_prot, chk_sup, err_pending,
                             state != S_IDLE, status_word};
    wire [31:0] ctrl_word = {26'h0000000, check_each, auto_array, 1'b0,
                             3'(op)};
    logic [31:0] rd_mux;
    always_comb begin
        case (ADDR_I)
            flash_seq_pkg::REG_CTRL:  rd_mux = ctrl_word;
            flash_seq_pkg::REG_ADDR:  rd_mux = 32'(tgt_addr);
            flash_seq_pkg::REG_WDATA: rd_mux = 32'(wdata);
            flash_seq_pkg::REG_STAT:  rd_mux = stat_word;
            flash_seq_pkg::REG_IRQ:   rd_mux = 32'(irq_stat);
            flash_seq_pkg::REG_MASK:  rd_mux = 32'(irq_mask);
            flash_seq_pkg::REG_RDATA: rd_mux = 32'(last_read);
            default:                  rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            RDATA_O <= 32'h00000000;
            IRQ_O   <= 1'b0;
        end else begin
            RDATA_O <= RD_I ? rd_mux : 32'h00000000;
            IRQ_O   <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin engine and status decoding
    flash_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
        .clock_i   (CLOCK_I),
        .reset_n_i (RESET_N_I),
        .start_i   (cyc_start),
        .read_i    (step_read),
        .addr_i    (step_addr),
        .data_i    (step_data),
        .busy_o    (cyc_busy),
        .done_o    (cyc_done),
        .rdata_o   (cyc_rdata),
        .fa_o      (FA_O),
        .fd_o      (FD_O),
        .fd_i      (FD_I),
        .fd_oe_n_o (FD_OE_N_O),
        .ce_n_o    (CE_N_O),
        .we_n_o    (WE_N_O),
        .oe_n_o    (OE_N_O)
    );

    flash_status_check u_check (
        .clock_i       (CLOCK_I),
        .reset_n_i     (RESET_N_I),
        .load_i        (status_load),
        .status_word_i (cyc_rdata[7:0]),
        .supply_low_o  (chk_sup),
        .protect_o     (chk_prot),
        .seq_err_o     (chk_seq),
        .erase_err_o   (chk_era),
        .write_err_o   (chk_wr),
        .any_err_o     (chk_any)
    );

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESET_N_I);

    sequence ready_read_s;
        state == S_PRE_RD && cyc_done && rd_ready;
    endsequence
    sequence op_enter_s;
        state == S_OP_1 && cyc_start;
    endsequence

    AST_POLL_BEFORE_OP: assert property (
        ready_read_s ##0 op_mod |=> ##[0:3] op_enter_s)
        else $error("no setup write after ready status");
    AST_POLL_AFTER_OP: assert property (
        state == S_OP_2 && cyc_done |=> state == S_POST_RD ##[1:3] cyc_start)
        else $error("no status poll after operation");
    AST_ERASE_SETUP: assert property (
        op_enter_s ##0 op == flash_seq_pkg::OP_CHIP_ERASE
        |-> step_data == DW'(flash_seq_pkg::CMD_CHIP_SETUP))
        else $error("wrong chip erase setup code");
    AST_ERASE_CONFIRM: assert property (
        state == S_OP_2 && cyc_start && op == flash_seq_pkg::OP_CHIP_ERASE
        |=> FD_O == DW'(flash_seq_pkg::CMD_CONFIRM) && !WE_N_O)
        else $error("wrong chip erase confirm on pins");
    AST_WORD_DATA: assert property (
        state == S_OP_2 && cyc_start && op == flash_seq_pkg::OP_WORD_WRITE
        |=> FD_O == wdata && FA_O == tgt_addr && !FD_OE_N_O)
        else $error("word data not driven at target");
    AST_REFUSE_AFTER_ERR: assert property (
        refuse |=> state == S_IDLE && irq_stat[flash_seq_pkg::IRQ_REFUSE])
        else $error("operation accepted with error pending");
    AST_ARRAY_CODE: assert property (
        state == S_ARRAY && cyc_start
        |=> FD_O == DW'(flash_seq_pkg::CMD_READ_ARRAY))
        else $error("read array code missing");
    AST_CHECK_EACH: assert property (
        state == S_FINISH && chk_any && !timeout && check_each && op_mod
        |=> err_pending && irq_stat[flash_seq_pkg::IRQ_ERROR])
        else $error("error not latched after operation");
endmodule : flash_seq_host
`default_nettype wire

// file: verif/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
    input  wire logic [19:0] fa_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        ce_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [4:0]  fault_i,
    output logic      [15:0] dq_o
);
    // fault_i: erase fail, write fail, all locked, low supply, bad sequence
    logic [7:0]  sr = 8'h80;
    logic [15:0] mem [0:15];
    logic        stat = 1'b0;
    logic [1:0]  pend = 2'b00;
    int          busy = 0;
    initial begin
        dq_o = 16'h0000;
        for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
    end
    logic [19:0] a_l = 20'h00000;
    logic [15:0] d_l = 16'h0000;
    logic        armed = 1'b0;
    // capture pins while the write strobe is low: the controller releases
    // chip enable and data in the same step as the strobe rises
    always @(we_n_i or ce_n_i or dq_i or fa_i)
        if (!we_n_i && !ce_n_i) begin
            a_l = fa_i;
            d_l = dq_i;
            armed = 1'b1;
        end
    always @(posedge we_n_i) if (armed) begin
        armed = 1'b0;
        stat = 1'b1;
        if (pend == 2'b01) begin
            mem[a_l[3:0]] = d_l;
            busy = 3;
            sr[3] |= fault_i[3];
            sr[4] |= fault_i[1] & !fault_i[3];
        end else if (pend == 2'b10) begin
            if (d_l[7:0] !== 8'hd0 || fault_i[4]) sr[5:4] = 2'b11;
            else if (fault_i[2]) sr[1] = 1'b1;
            else begin
                busy = 3;
                for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
                sr[3] |= fault_i[3];
                sr[5] |= fault_i[0] & !fault_i[3];
            end
        end else case (d_l[7:0])
            8'h40, 8'h10: pend = 2'b01;
            8'h30: pend = 2'b10;
            8'h50: sr = sr & 8'hc5;
            8'hff: stat = 1'b0;
            default: ;
        endcase
        if (pend != 2'b00 && d_l[7:0] !== 8'h40 && d_l[7:0] !== 8'h10
            && d_l[7:0] !== 8'h30) pend = 2'b00;
        sr[7] = (busy == 0);
    end
    always @(negedge oe_n_i) if (!ce_n_i) begin
        dq_o = (stat || busy > 0) ? {8'h00, sr} : mem[fa_i[3:0]];
        if (busy > 0) busy--;
        sr[7] = (busy == 0);
    end
    // released data lines do not keep the last value
    always @(posedge oe_n_i) dq_o = ~dq_o;
endmodule : flash_dev_model
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata, got;
    logic [19:0] fa;
    logic [15:0] fdo, fdm, dq;
    logic        irq, fd_oe_n, ce_n, we_n, oe_n;
    logic [4:0]  fault = 5'h00;
    logic        auto_arr = 1'b0;
    int          err_total = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [4:0]  flt [4] = '{5'h04, 5'h08, 5'h10, 5'h01};
    logic [31:0] exs [4] = '{32'h0a82, 32'h0688, 32'h12b0, 32'h22a0};
    assign dq = !fd_oe_n ? fdo : fdm;
    flash_seq_host #(.POLL_LIMIT(24'h000008)) flash_seq_host_i (
        .CLOCK_I(clock), .RESET_N_I(reset_n), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .IRQ_O(irq), .FA_O(fa), .FD_O(fdo), .FD_I(dq),
        .FD_OE_N_O(fd_oe_n), .CE_N_O(ce_n), .WE_N_O(we_n), .OE_N_O(oe_n));
    flash_dev_model flash_dev_model_i (.fa_i(fa), .dq_i(dq), .ce_n_i(ce_n),
        .we_n_i(we_n), .oe_n_i(oe_n), .fault_i(fault), .dq_o(fdm));
    initial forever #12.5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : rd_reg
    task automatic chk(input logic [31:0] g, e, input string m);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task automatic run(input logic [2:0] op, input logic each);
        wr_reg(flash_seq_pkg::REG_CTRL, {26'h0, each, auto_arr, 1'b1, op});
        repeat (4) @(posedge clock);
        for (int i = 0; i < 500; i++) begin
            rd_reg(flash_seq_pkg::REG_STAT);
            if (got[8] === 1'b0) break;
        end
        chk({31'h0, got[8]}, 32'h0, "op stuck");
    endtask : run
    task automatic stat(input logic [31:0] e, input string m);
        rd_reg(flash_seq_pkg::REG_STAT);
        chk(got & 32'hffff, e, m);
    endtask : stat
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    always @(posedge clock) begin
        cycles++;
        if (cycles == 100000) begin
            err_total++;
            final_report;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clock);
        chk({28'h0, ce_n, we_n, oe_n, fd_oe_n}, 32'hf, "idle pins");
        reset_n <= 1'b1;
        run(3'h0, 1'b1);
        stat(32'h0080, "erase ok");
        wr_reg(flash_seq_pkg::REG_ADDR, 32'h5);
        wr_reg(flash_seq_pkg::REG_WDATA, 32'h1234);
        auto_arr = 1'b1;
        run(3'h1, 1'b1);
        auto_arr = 1'b0;
        chk({16'h0, flash_dev_model_i.mem[5]}, 32'h1234, "data");
        chk({31'h0, flash_dev_model_i.stat}, 32'h0, "auto array");
        fault = 5'h02;
        run(3'h1, 1'b1);
        stat(32'h4290, "write fail");
        chk({31'h0, irq}, 32'h0, "masked irq");
        wr_reg(flash_seq_pkg::REG_MASK, 32'h2);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h1, "irq on");
        wr_reg(flash_seq_pkg::REG_IRQ, 32'hf);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0, "irq off");
        run(3'h0, 1'b1);
        rd_reg(flash_seq_pkg::REG_IRQ);
        chk(got & 32'h4, 32'h4, "refused");
        run(3'h2, 1'b1);
        for (int i = 0; i < 4; i++) begin
            fault = flt[i];
            run(3'h0, 1'b1);
            stat(exs[i], "erase error");
            fault = 5'h00;
            run(3'h2, 1'b1);
        end
        fault = 5'h01;
        run(3'h0, 1'b0);
        fault = 5'h00;
        run(3'h0, 1'b0);
        run(3'h4, 1'b0);
        stat(32'h22a0, "erase accum");
        run(3'h2, 1'b1);
        fault = 5'h02;
        run(3'h1, 1'b0);
        fault = 5'h00;
        run(3'h1, 1'b0);
        run(3'h4, 1'b0);
        stat(32'h4290, "write accum");
        run(3'h2, 1'b1);
        run(3'h0, 1'b1);
        stat(32'h0080, "cleared");
        run(3'h3, 1'b1);
        chk({31'h0, flash_dev_model_i.stat}, 32'h0, "array");
        rd_reg(4'h7);
        chk(got, 32'h0, "unmapped");
        final_report;
    end
endmodule : tb_top
`default_nettype wire
